// [rtl/shi_serial_host_interface.sv]
`timescale 1ns/10ps
`default_nettype none

module shi_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wr_idx;
  logic push;
  logic pop;

  // Head always sits in slot 0 so the output is a flop
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign wr_idx = pop ? count - CW'(1) : count;
  assign next_count = count + CW'(push) - CW'(pop);
  assign out_data_o = mem[0];

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && CW'(i) == wr_idx) begin
          mem[i] <= in_data_i;
        end else if (pop) begin
          mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= '0;
      out_valid_o <= 1'b0;
      in_ready_o <= 1'b0;
    end else begin
      count <= next_count;
      out_valid_o <= next_count != '0;
      in_ready_o <= next_count != CW'(DEPTH);
    end
  end
endmodule

module shi_serial_host_interface #(
  parameter int FIFO_DEPTH = shi_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sync_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] address_strap_pin_i,
  input wire logic readback_output_enable_i,
  input wire logic readback_edge_select_i,
  input wire logic [15:0] rd_data_i,
  output logic [6:0] rd_addr_o,
  output var shi_pkg::shi_cmd_t cmd_data_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic soft_reset_o,
  output var shi_pkg::shi_proto_t proto_o
);
  logic [shi_pkg::PIN_W-1:0] pin_raw;
  logic [shi_pkg::PIN_W-1:0] pin_s1;
  logic [shi_pkg::PIN_W-1:0] pin_s2;
  logic [shi_pkg::PIN_W-1:0] pin_s3;
  logic [shi_pkg::PIN_W-1:0] pin_f;
  logic [shi_pkg::PIN_W-1:0] pin_fp;
  logic sclk_fall, sclk_rise, sync_fall, sync_rise;
  logic scl_fall, scl_rise, scl_high, start_ev, stop_ev;
  logic spi_allowed, spi_act, frame_start, spi_done, spi_frame_ok;
  logic [4:0] spi_edge_cnt;
  logic spi_full, spi_rb_en, spi_rb_edge;
  logic [shi_pkg::SPI_FRAME_BITS-1:0] spi_in_sr;
  logic [shi_pkg::SPI_FRAME_BITS-1:0] spi_out_sr;
  logic prev_rw;
  logic [6:0] prev_addr;
  logic i2c_ok, byte_end, addr_match, gc_match, rx_ack, i2c_cmd_ld, i2c_lsb_ack;
  shi_pkg::shi_i2c_state_t i2c_st;
  logic [3:0] i2c_cnt;
  logic [7:0] i2c_sr, i2c_msb, i2c_tx, tx_next;
  logic [1:0] i2c_idx;
  logic [2:0] i2c_strap;
  logic i2c_read, i2c_gc, i2c_gc_arm, i2c_tx_lo;
  shi_pkg::shi_cmd_t push_data;
  logic push_valid, fifo_in_ready;

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  // Three-stage synchroniser; a level is taken once stages two and three agree
  assign pin_raw = {address_strap_pin_i, sda_i, scl_i, spi_sdi_i, spi_sync_n_i, spi_sclk_i};
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1 <= shi_pkg::PIN_RESET;
      pin_s2 <= shi_pkg::PIN_RESET;
      pin_s3 <= shi_pkg::PIN_RESET;
      pin_f <= shi_pkg::PIN_RESET;
      pin_fp <= shi_pkg::PIN_RESET;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
      pin_fp <= pin_f;
    end
  end

  assign sclk_fall = fell(pin_fp[shi_pkg::PIN_SCLK], pin_f[shi_pkg::PIN_SCLK]);
  assign sclk_rise = fell(pin_f[shi_pkg::PIN_SCLK], pin_fp[shi_pkg::PIN_SCLK]);
  assign sync_fall = fell(pin_fp[shi_pkg::PIN_SYNC], pin_f[shi_pkg::PIN_SYNC]);
  assign sync_rise = fell(pin_f[shi_pkg::PIN_SYNC], pin_fp[shi_pkg::PIN_SYNC]);
  assign scl_fall = fell(pin_fp[shi_pkg::PIN_SCL], pin_f[shi_pkg::PIN_SCL]);
  assign scl_rise = fell(pin_f[shi_pkg::PIN_SCL], pin_fp[shi_pkg::PIN_SCL]);
  assign scl_high = pin_f[shi_pkg::PIN_SCL] & pin_fp[shi_pkg::PIN_SCL];
  assign start_ev = scl_high & fell(pin_fp[shi_pkg::PIN_SDA], pin_f[shi_pkg::PIN_SDA]);
  assign stop_ev = scl_high & fell(pin_f[shi_pkg::PIN_SDA], pin_fp[shi_pkg::PIN_SDA]);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      proto_o <= shi_pkg::PROTO_NONE;
    end else if (proto_o == shi_pkg::PROTO_NONE) begin
      if (sync_fall) begin
        proto_o <= shi_pkg::PROTO_SPI;
      end else if (start_ev) begin
        proto_o <= shi_pkg::PROTO_I2C;
      end
    end
  end

  // SPI side: frame select high blocks clock and data
  assign spi_allowed = proto_o != shi_pkg::PROTO_I2C;
  assign spi_act = spi_allowed & ~pin_f[shi_pkg::PIN_SYNC];
  assign frame_start = spi_allowed & sync_fall;
  assign spi_frame_ok = spi_full & (~spi_rb_en | (spi_edge_cnt == '0));
  assign spi_done = spi_allowed & sync_rise & spi_frame_ok;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_edge_cnt <= '0;
      spi_full <= 1'b0;
      spi_rb_en <= 1'b0;
      spi_rb_edge <= 1'b0;
      spi_in_sr <= '0;
      spi_out_sr <= '0;
    end else if (frame_start) begin
      spi_edge_cnt <= '0;
      spi_full <= 1'b0;
      spi_rb_en <= readback_output_enable_i;
      spi_rb_edge <= readback_edge_select_i;
      spi_out_sr <= {prev_rw, prev_addr, rd_data_i};
    end else if (spi_act) begin
      if (sclk_fall) begin
        if (spi_edge_cnt == shi_pkg::SPI_LAST_EDGE) begin
          spi_edge_cnt <= '0;
          spi_full <= 1'b1;
        end else begin
          spi_edge_cnt <= spi_edge_cnt + 5'h01;
        end
        // Three-wire keeps the first 24 bits, four-wire the last 24
        if (spi_rb_en | ~spi_full) begin
          spi_in_sr <= {spi_in_sr[shi_pkg::SPI_FRAME_BITS-2:0], pin_f[shi_pkg::PIN_SDI]};
        end
      end
      // Output shifts on the chosen edge and refills from the input, forming the chain
      if (spi_rb_edge & sclk_fall) begin
        spi_out_sr <= {spi_out_sr[shi_pkg::SPI_FRAME_BITS-2:0], pin_f[shi_pkg::PIN_SDI]};
      end else if (~spi_rb_edge & sclk_rise) begin
        spi_out_sr <= {spi_out_sr[shi_pkg::SPI_FRAME_BITS-2:0], spi_in_sr[0]};
      end
    end
  end

  assign spi_sdo_o = spi_out_sr[shi_pkg::SPI_RW_BIT];

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      spi_sdo_oe_o <= 1'b0;
      prev_rw <= 1'b0;
      prev_addr <= '0;
    end else begin
      spi_sdo_oe_o <= spi_act & readback_output_enable_i;
      if (spi_done) begin
        prev_rw <= spi_in_sr[shi_pkg::SPI_RW_BIT];
        prev_addr <= spi_in_sr[shi_pkg::SPI_ADDR_MSB:shi_pkg::SPI_ADDR_LSB];
      end
    end
  end

  // I2C target side
  assign i2c_ok = proto_o != shi_pkg::PROTO_SPI;
  assign byte_end = scl_fall & (i2c_cnt == shi_pkg::I2C_BYTE_END);
  assign addr_match = i2c_sr[7:1] == {shi_pkg::I2C_ADDR_HI, i2c_strap};
  assign gc_match = i2c_sr == shi_pkg::I2C_GCALL_ADDR;
  assign rx_ack = i2c_gc ? (i2c_sr == shi_pkg::I2C_GCALL_RESET) :
                  ((i2c_idx != shi_pkg::IDX_LSB) | fifo_in_ready);
  assign i2c_cmd_ld = byte_end & (i2c_st == shi_pkg::I_RX) & ~i2c_gc &
                      (i2c_idx == shi_pkg::IDX_CMD);
  assign i2c_lsb_ack = byte_end & (i2c_st == shi_pkg::I_RX) & ~i2c_gc &
                       (i2c_idx == shi_pkg::IDX_LSB) & fifo_in_ready;
  assign tx_next = i2c_tx_lo ? rd_data_i[7:0] : rd_data_i[15:8];

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      i2c_st <= shi_pkg::I_IDLE;
      i2c_cnt <= '0;
      i2c_sr <= '0;
      i2c_msb <= '0;
      i2c_tx <= '0;
      i2c_idx <= shi_pkg::IDX_CMD;
      i2c_strap <= '0;
      i2c_read <= 1'b0;
      i2c_gc <= 1'b0;
      i2c_gc_arm <= 1'b0;
      i2c_tx_lo <= 1'b0;
      sda_oe_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      soft_reset_o <= 1'b0;
      if (~i2c_ok | stop_ev) begin
        i2c_st <= shi_pkg::I_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_ev) begin
        i2c_st <= shi_pkg::I_ADDR;
        i2c_cnt <= '0;
        i2c_idx <= shi_pkg::IDX_CMD;
        i2c_gc <= 1'b0;
        i2c_gc_arm <= 1'b0;
        i2c_strap <= pin_f[shi_pkg::PIN_STRAP +: 3];
        sda_oe_o <= 1'b0;
      end else begin
        case (i2c_st)
          shi_pkg::I_ADDR, shi_pkg::I_RX: begin
            if (scl_rise) begin
              i2c_sr <= {i2c_sr[6:0], pin_f[shi_pkg::PIN_SDA]};
              i2c_cnt <= i2c_cnt + 4'h1;
            end else if (byte_end) begin
              i2c_cnt <= '0;
              if (i2c_st == shi_pkg::I_ADDR) begin
                if (addr_match | gc_match) begin
                  i2c_st <= shi_pkg::I_ACK;
                  sda_oe_o <= 1'b1;
                  i2c_read <= i2c_sr[0] & addr_match;
                  i2c_gc <= gc_match;
                  i2c_tx_lo <= 1'b0;
                end else begin
                  i2c_st <= shi_pkg::I_IDLE;
                end
              end else begin
                i2c_st <= shi_pkg::I_ACK;
                sda_oe_o <= rx_ack;
                if (i2c_gc) begin
                  i2c_gc_arm <= rx_ack;
                end else if (i2c_idx == shi_pkg::IDX_CMD) begin
                  i2c_idx <= shi_pkg::IDX_MSB;
                end else if (i2c_idx == shi_pkg::IDX_MSB) begin
                  i2c_msb <= i2c_sr;
                  i2c_idx <= shi_pkg::IDX_LSB;
                end else if (rx_ack) begin
                  i2c_idx <= shi_pkg::IDX_MSB;
                end
              end
            end
          end
          shi_pkg::I_ACK: begin
            if (scl_rise & i2c_gc_arm) begin
              soft_reset_o <= 1'b1;
              i2c_gc_arm <= 1'b0;
            end else if (scl_fall) begin
              if (i2c_read) begin
                i2c_st <= shi_pkg::I_TX;
                sda_oe_o <= ~tx_next[7];
                i2c_tx <= {tx_next[6:0], 1'b0};
                i2c_tx_lo <= ~i2c_tx_lo;
                i2c_cnt <= 4'h1;
              end else begin
                i2c_st <= shi_pkg::I_RX;
                sda_oe_o <= 1'b0;
              end
            end
          end
          shi_pkg::I_TX: begin
            if (scl_fall) begin
              if (i2c_cnt == shi_pkg::I2C_BYTE_END) begin
                i2c_st <= shi_pkg::I_MACK;
                sda_oe_o <= 1'b0;
                i2c_cnt <= '0;
              end else begin
                sda_oe_o <= ~i2c_tx[7];
                i2c_tx <= {i2c_tx[6:0], 1'b0};
                i2c_cnt <= i2c_cnt + 4'h1;
              end
            end
          end
          shi_pkg::I_MACK: begin
            if (scl_rise & pin_f[shi_pkg::PIN_SDA]) begin
              i2c_st <= shi_pkg::I_IDLE;
            end else if (scl_fall) begin
              i2c_st <= shi_pkg::I_TX;
              sda_oe_o <= ~tx_next[7];
              i2c_tx <= {tx_next[6:0], 1'b0};
              i2c_tx_lo <= ~i2c_tx_lo;
              i2c_cnt <= 4'h1;
            end
          end
          default: begin
            i2c_st <= shi_pkg::I_IDLE;
          end
        endcase
      end
    end
  end

  // Lines are only pulled low; the clock is never held
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_addr_o <= '0;
    end else if (spi_done) begin
      rd_addr_o <= spi_in_sr[shi_pkg::SPI_ADDR_MSB:shi_pkg::SPI_ADDR_LSB];
    end else if (i2c_cmd_ld) begin
      rd_addr_o <= i2c_sr[6:0];
    end
  end

  // A full buffer drops the SPI frame and refuses the I2C low data byte
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      push_valid <= 1'b0;
      push_data <= '0;
    end else begin
      push_valid <= (spi_done & fifo_in_ready) | i2c_lsb_ack;
      if (spi_done) begin
        push_data <= shi_pkg::shi_cmd_t'{from_i2c: 1'b0,
          rw: spi_in_sr[shi_pkg::SPI_RW_BIT],
          addr: spi_in_sr[shi_pkg::SPI_ADDR_MSB:shi_pkg::SPI_ADDR_LSB],
          data: spi_in_sr[shi_pkg::SPI_DATA_MSB:0]};
      end else if (i2c_lsb_ack) begin
        push_data <= shi_pkg::shi_cmd_t'{from_i2c: 1'b1, rw: 1'b0, addr: rd_addr_o,
          data: {i2c_msb, i2c_sr}};
      end
    end
  end

  shi_fifo #(
    .WIDTH($bits(shi_pkg::shi_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(cmd_valid_o),
    .out_ready_i(cmd_ready_i),
    .out_data_o(cmd_data_o)
  );

  property p_sdo_off;
    @(posedge mclk_i) disable iff (reset_i) pin_f[shi_pkg::PIN_SYNC] |=> !spi_sdo_oe_o;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("sdo driven with select high");

  property p_sdo_needs_en;
    @(posedge mclk_i) disable iff (reset_i) spi_sdo_oe_o |-> $past(readback_output_enable_i);
  endproperty
  a_sdo_needs_en: assert property (p_sdo_needs_en) else $error("sdo without enable");

  property p_spi_whole;
    @(posedge mclk_i) disable iff (reset_i)
      (push_valid && !push_data.from_i2c && $past(spi_rb_en)) |-> $past(spi_edge_cnt) == '0;
  endproperty
  a_spi_whole: assert property (p_spi_whole) else $error("partial frame accepted");

  property p_spi_full;
    @(posedge mclk_i) disable iff (reset_i) (push_valid && !push_data.from_i2c) |-> $past(spi_full);
  endproperty
  a_spi_full: assert property (p_spi_full) else $error("short frame accepted");

  property p_echo;
    @(posedge mclk_i) disable iff (reset_i)
      frame_start |=> spi_out_sr[shi_pkg::SPI_RW_BIT:shi_pkg::SPI_ADDR_LSB] ==
        $past({prev_rw, prev_addr});
  endproperty
  a_echo: assert property (p_echo) else $error("echo header wrong");

  property p_open_drain;
    @(posedge mclk_i) disable iff (reset_i) sda_oe_o |-> (!sda_o && !scl_oe_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_ack_hold;
    @(posedge mclk_i) disable iff (reset_i)
      (i2c_st == shi_pkg::I_ACK && sda_oe_o && pin_f[shi_pkg::PIN_SCL] && !start_ev && !stop_ev)
        |=> sda_oe_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released while scl high");

  property p_tx_stable;
    @(posedge mclk_i) disable iff (reset_i)
      (i2c_st == shi_pkg::I_TX && pin_f[shi_pkg::PIN_SCL] && !start_ev && !stop_ev)
        |=> $stable(sda_oe_o);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("sda changed while scl high");

  property p_stop;
    @(posedge mclk_i) disable iff (reset_i)
      (i2c_ok && stop_ev) |=> (i2c_st == shi_pkg::I_IDLE && !sda_oe_o);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not release bus");

  property p_start;
    @(posedge mclk_i) disable iff (reset_i)
      (i2c_ok && start_ev) |=> i2c_st == shi_pkg::I_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_no_match;
    @(posedge mclk_i) disable iff (reset_i)
      (i2c_ok && i2c_st == shi_pkg::I_ADDR && byte_end && !addr_match && !gc_match)
        |=> (i2c_st == shi_pkg::I_IDLE && !sda_oe_o);
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign address acknowledged");

  property p_gc_reset;
    @(posedge mclk_i) disable iff (reset_i)
      soft_reset_o |-> ($past(i2c_st) == shi_pkg::I_ACK && $past(i2c_gc) && $past(scl_rise));
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("reset outside general call ack");

  property p_lock;
    @(posedge mclk_i) disable iff (reset_i) (proto_o != shi_pkg::PROTO_NONE) |=> $stable(proto_o);
  endproperty
  a_lock: assert property (p_lock) else $error("protocol changed after lock");
endmodule

`default_nettype wire

// [rtl/shi_pkg.sv]
package shi_pkg;
  localparam int SPI_FRAME_BITS = 24;
  localparam int SPI_RW_BIT = 23;
  localparam int SPI_ADDR_MSB = 22;
  localparam int SPI_ADDR_LSB = 16;
  localparam int SPI_DATA_MSB = 15;
  localparam logic [4:0] SPI_LAST_EDGE = 5'h17;
  localparam logic [3:0] I2C_ADDR_HI = 4'h9;
  localparam logic [7:0] I2C_GCALL_ADDR = 8'h00;
  localparam logic [7:0] I2C_GCALL_RESET = 8'h06;
  localparam logic [3:0] I2C_BYTE_END = 4'h8;
  localparam logic [1:0] IDX_CMD = 2'h0;
  localparam logic [1:0] IDX_MSB = 2'h1;
  localparam logic [1:0] IDX_LSB = 2'h2;
  localparam int PIN_W = 8;
  localparam logic [7:0] PIN_RESET = 8'h1f;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_SCL = 3;
  localparam int PIN_SDA = 4;
  localparam int PIN_STRAP = 5;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    PROTO_NONE = 3'b001,
    PROTO_SPI = 3'b010,
    PROTO_I2C = 3'b100
  } shi_proto_t;

  typedef enum logic [5:0] {
    I_IDLE = 6'b000001,
    I_ADDR = 6'b000010,
    I_ACK = 6'b000100,
    I_RX = 6'b001000,
    I_TX = 6'b010000,
    I_MACK = 6'b100000
  } shi_i2c_state_t;

  typedef struct packed {
    logic from_i2c;
    logic rw;
    logic [6:0] addr;
    logic [15:0] data;
  } shi_cmd_t;
endpackage

// [bench/shi_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module shi_host_model (
  input wire logic mclk_i,
  input wire logic sdo_i,
  input wire logic sda_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic sdi_o,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    sdi_o = 1'b1;
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // SDO is read two cycles after each falling SCLK, ahead of the synchronised shift
  task automatic spi_frame(input logic [71:0] bits, input int n, output logic [71:0] seen);
    seen = 72'h0;
    sync_n_o = 1'b0;
    tick(6);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o = bits[i];
      tick(4);
      sclk_o = 1'b0;
      tick(2);
      seen[i] = sdo_i;
      tick(2);
    end
    sync_n_o = 1'b1;
    tick(2);
    sclk_o = 1'b1;
    sdi_o = ~sdi_o;
    tick(8);
  endtask
  task automatic i2c_start;
    sda_low_o = 1'b0;
    scl_o = 1'b1;
    tick(10);
    sda_low_o = 1'b1;
    tick(10);
    scl_o = 1'b0;
    tick(5);
  endtask
  task automatic i2c_stop;
    sda_low_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(10);
    sda_low_o = 1'b0;
    tick(10);
  endtask
  task automatic i2c_byte(input logic [7:0] b, input logic drv_ack, output logic ack,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o = ~b[i];
      tick(5);
      scl_o = 1'b1;
      tick(5);
      rx[i] = sda_i;
      tick(5);
      scl_o = 1'b0;
      tick(5);
    end
    sda_low_o = drv_ack;
    tick(5);
    scl_o = 1'b1;
    tick(5);
    ack = (sda_i === 1'b0);
    tick(5);
    scl_o = 1'b0;
    tick(5);
  endtask
endmodule
`default_nettype wire

// [bench/test_serial_host_interface.sv]
`timescale 1ns/10ps
`default_nettype none
module test_serial_host_interface;
  logic mclk_i, reset_i, rbk_en, cmd_ready, sr_seen, ack, sda_w, scl_w;
  logic sclk, sync_n, sdi, scl_c, sda_low, sdo, sdo_oe, scl_o, scl_oe, sda_o, sda_oe;
  logic soft_reset, cmd_valid, rbk_edge;
  logic [7:0] rx;
  logic [6:0] rd_addr;
  logic [15:0] rd_data;
  logic [71:0] seen;
  shi_pkg::shi_cmd_t cmd;
  shi_pkg::shi_proto_t proto;
  int num_errors, tests_run;
  // Open-drain wires with pull-ups
  assign sda_w = ~(sda_oe | sda_low);
  assign scl_w = ~(scl_oe | ~scl_c);
  assign rd_data = {9'h14a, rd_addr};
  shi_serial_host_interface i_shi_serial_host_interface (.mclk_i(mclk_i), .reset_i(reset_i),
    .spi_sclk_i(sclk), .spi_sync_n_i(sync_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
    .spi_sdo_oe_o(sdo_oe), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .address_strap_pin_i(3'h5),
    .readback_output_enable_i(rbk_en), .readback_edge_select_i(rbk_edge), .rd_data_i(rd_data),
    .rd_addr_o(rd_addr), .cmd_data_o(cmd), .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
    .soft_reset_o(soft_reset), .proto_o(proto));
  shi_host_model i_shi_host_model (.mclk_i(mclk_i), .sdo_i(sdo), .sda_i(sda_w), .sclk_o(sclk),
    .sync_n_o(sync_n), .sdi_o(sdi), .scl_o(scl_c), .sda_low_o(sda_low));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (soft_reset === 1'b1) sr_seen <= 1'b1;
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic pop(input logic [24:0] exp);
    int n;
    n = 0;
    while (cmd_valid !== 1'b1 && n < 80) begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 80) begin
      check("cmd_valid", 32'h0, 32'h1);
      close_out();
    end
    check("cmd_data", cmd, exp);
    cmd_ready = 1'b1;
    @(negedge mclk_i);
    cmd_ready = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic none_left;
    repeat (30) @(negedge mclk_i);
    check("cmd_valid_idle", cmd_valid, 32'h0);
  endtask
  task automatic frame(input logic [71:0] b, input int n);
    i_shi_host_model.spi_frame(b, n, seen);
  endtask
  task automatic ib(input logic [7:0] b, input logic exp);
    i_shi_host_model.i2c_byte(b, 1'b0, ack, rx);
    check("i2c_ack", ack, exp);
  endtask
  task automatic rb(input logic [7:0] exp, input logic mack);
    i_shi_host_model.i2c_byte(8'hff, mack, ack, rx);
    check("i2c_rd", rx, exp);
  endtask
  task automatic t_three_wire;
    frame({48'h0, 24'h123456}, 24);
    pop({2'b00, 7'h12, 16'h3456});
    check("proto_spi", proto, shi_pkg::PROTO_SPI);
    frame(72'habcd, 16);
    none_left();
    frame({42'h0, 24'h05a5a5, 6'h2a}, 30);
    pop({2'b00, 7'h05, 16'ha5a5});
  endtask
  task automatic t_fifo_full;
    for (int i = 0; i < 5; i++) frame({48'h0, 8'h20 + 8'(i), 16'h0f00}, 24);
    for (int i = 0; i < 4; i++) pop({2'b00, 7'h20 + 7'(i), 16'h0f00});
    none_left();
  endtask
  task automatic t_four_wire;
    rbk_en = 1'b1;
    frame({24'h0, 24'h111111, 24'haa2a00}, 48);
    check("sdo_chain", seen[23:0], 24'h111111);
    pop({2'b01, 7'h2a, 16'h2a00});
    frame({48'h0, 24'h113300}, 24);
    check("sdo_echo", seen[23:0], {1'b1, 7'h2a, 16'ha52a});
    pop({2'b00, 7'h11, 16'h3300});
    rbk_edge = 1'b0;
    frame({48'h0, 24'h113300}, 24);
    check("sdo_echo_rise", seen[23:0], {1'b0, 7'h11, 16'ha511});
    pop({2'b00, 7'h11, 16'h3300});
    rbk_edge = 1'b1;
    check("sdo_oe_idle", sdo_oe, 32'h0);
    frame(72'h0, 30);
    none_left();
    rbk_en = 1'b0;
  endtask
  task automatic t_i2c;
    reset_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    i_shi_host_model.i2c_start();
    ib(8'h9a, 1'b1);
    ib(8'h05, 1'b1);
    ib(8'hbe, 1'b1);
    ib(8'hef, 1'b1);
    i_shi_host_model.i2c_stop();
    pop({2'b10, 7'h05, 16'hbeef});
    check("proto_i2c", proto, shi_pkg::PROTO_I2C);
    i_shi_host_model.i2c_start();
    ib(8'h9a, 1'b1);
    ib(8'h33, 1'b1);
    i_shi_host_model.i2c_start();
    ib(8'h9b, 1'b1);
    rb(8'ha5, 1'b1);
    rb(8'h33, 1'b0);
    i_shi_host_model.i2c_stop();
    i_shi_host_model.i2c_start();
    ib(8'h98, 1'b0);
    i_shi_host_model.i2c_start();
    ib(8'hf0, 1'b0);
    i_shi_host_model.i2c_start();
    ib(8'h00, 1'b1);
    sr_seen = 1'b0;
    ib(8'h06, 1'b1);
    check("soft_reset", sr_seen, 32'h1);
    i_shi_host_model.i2c_stop();
    frame({48'h0, 24'h123456}, 24);
    none_left();
  endtask
  initial begin
    num_errors = 0;
    tests_run = 0;
    reset_i = 1'b1;
    rbk_en = 1'b0;
    rbk_edge = 1'b1;
    cmd_ready = 1'b0;
    sr_seen = 1'b0;
    repeat (8) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (5) @(negedge mclk_i);
    t_three_wire();
    t_fifo_full();
    t_four_wire();
    t_i2c();
    close_out();
  end
endmodule
`default_nettype wire
